// ===== hw/mtrl_lookup_unit.sv
/*
 * mtrl_lookup_unit: memory type range registers and the physical address
 * lookup that resolves the effective memory type of an access.
 * Assumes: the core register-write logic issues model register reads and
 * writes one at a time on SYS_CLK, and the access path samples the answer
 * one cycle after its request.
 */
`timescale 1ns/100ps

// Notes on behaviour
// - default field bits 7:0 gives type for addresses no range covers
// - default type accepts only 0,1,4,5,6; other values fault
// - global enable bit 11 clear forces uncacheable everywhere
// - bit 10 switches all fixed ranges on or off
// - enabled fixed range wins over a matching variable range
// - fixed ranges off: variable pairs still apply in first megabyte
// - fixed enable has no effect while global enable is clear
// - enabled and nothing matches: use default type field
// - default register bits 8,9 and 12-63 reserved; nonzero write faults
// - eleven 64-bit fixed registers, eight byte-wide type fields each
// - first fixed register: 0 to 7FFFF in 64 KB steps, low byte first
// - next two: 80000 to BFFFF in 16 KB steps, ascending
// - last eight: C0000 to FFFFF in 4 KB steps, ascending
// - eight variable pairs of base and mask, indexed 0 to 7
// - base bits 7:0 give the pair's memory type
// - base bits 35:12 padded with twelve zeros form the base address
// - match when address AND mask equals base AND mask
// - valid bit 11 of the pair enables it for matching
// - reserved bits in base or mask writes fault
// - overlapping uncacheable with uncacheable or write-back gives uncacheable
// - gaps of discontinuous masks get the default type
// - type fields use 00,01,04,05,06; other encodings fault
// - reset clears pair valid bits and global enable
module mtrl_lookup_unit (
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RESET,
   // model register read and write port
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [7:0] REG_SEL,
   input wire logic [63:0] REG_WDATA,
   output logic [63:0] REG_RDATA,
   output logic REG_DONE,
   output logic REG_FAULT,
   // physical address lookup port
   input wire logic LOOKUP_REQ,
   input wire logic [35:0] LOOKUP_ADDR,
   output logic LOOKUP_VALID,
   output logic [7:0] LOOKUP_TYPE
);

   mtrl_pkg::mtrl_def_ctl_t def_q;
   mtrl_pkg::mtrl_var_pair_t var_q [0:mtrl_pkg::VARIABLE_COUNT-1];
   logic [7:0] fix_q [0:mtrl_pkg::FIXED_BYTES-1];
   logic [63:0] fix_word [0:mtrl_pkg::FIXED_COUNT-1];
   logic [63:0] rd_data;
   logic bad_wr;
   logic sel_def;
   logic sel_fix;
   logic sel_var;
   logic [3:0] fix_idx;
   logic [2:0] var_idx;
   logic [7:0] sel_off;
   logic fix_in;
   logic [6:0] fix_byte;
   logic [7:0] fix_type;
   logic var_any;
   logic var_uc;
   logic var_wt;
   logic var_wb;
   logic var_other;
   logic var_same;
   logic [7:0] var_first;
   logic [7:0] type_d;

   // gather each fixed register as a word, low byte field first
   always_comb begin
      for (int r = 0; r < mtrl_pkg::FIXED_COUNT; r++) begin
         for (int b = 0; b < 8; b++) begin
            fix_word[r][b*8 +: 8] = fix_q[r*8+b];
         end
      end
   end

   // register select decode
   always_comb begin
      sel_off = REG_SEL - mtrl_pkg::SEL_FIXED_FIRST;
      sel_def = (REG_SEL == mtrl_pkg::SEL_DEFAULT_TYPE_CONTROL);
      sel_fix = (REG_SEL >= mtrl_pkg::SEL_FIXED_FIRST) && (REG_SEL <= mtrl_pkg::SEL_FIXED_LAST);
      sel_var = (REG_SEL[7:4] == mtrl_pkg::SEL_VARIABLE_GROUP);
      fix_idx = sel_off[3:0];
      var_idx = REG_SEL[3:1];
   end

   // write legality; an unmapped select faults as well
   always_comb begin
      bad_wr = 1'b1;
      if (sel_def) begin
         bad_wr = (|(REG_WDATA & mtrl_pkg::DEF_RSVD_MASK)) ||
                  !mtrl_pkg::type_legal(REG_WDATA[7:0]);
      end else if (sel_fix) begin
         bad_wr = 1'b0;
         for (int b = 0; b < 8; b++) begin
            if (!mtrl_pkg::type_legal(REG_WDATA[b*8 +: 8])) begin
               bad_wr = 1'b1;
            end
         end
      end else if (sel_var && !REG_SEL[0]) begin
         bad_wr = (|(REG_WDATA & mtrl_pkg::BASE_RSVD_MASK)) ||
                  !mtrl_pkg::type_legal(REG_WDATA[7:0]);
      end else if (sel_var) begin
         bad_wr = |(REG_WDATA & mtrl_pkg::MASK_RSVD_MASK);
      end
   end

   // read mux; reserved bits read as zero
   always_comb begin
      rd_data = 64'h0000_0000_0000_0000;
      if (sel_def) begin
         rd_data[7:0] = def_q.dtype;
         rd_data[mtrl_pkg::DEF_FE_BIT] = def_q.fe;
         rd_data[mtrl_pkg::DEF_EN_BIT] = def_q.en;
      end else if (sel_fix) begin
         rd_data = fix_word[fix_idx];
      end else if (sel_var && !REG_SEL[0]) begin
         rd_data[7:0] = var_q[var_idx].btype;
         rd_data[mtrl_pkg::VAR_ADDR_MSB:mtrl_pkg::VAR_ADDR_LSB] = var_q[var_idx].base;
      end else if (sel_var) begin
         rd_data[mtrl_pkg::VAR_VALID_BIT] = var_q[var_idx].valid;
         rd_data[mtrl_pkg::VAR_ADDR_MSB:mtrl_pkg::VAR_ADDR_LSB] = var_q[var_idx].mask;
      end
   end

   // default-type control register; a faulting write leaves it untouched
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         def_q <= mtrl_pkg::DEF_CTL_RESET;
      end else if (REG_WR && sel_def && !bad_wr) begin
         def_q.dtype <= REG_WDATA[7:0];
         def_q.fe <= REG_WDATA[mtrl_pkg::DEF_FE_BIT];
         def_q.en <= REG_WDATA[mtrl_pkg::DEF_EN_BIT];
      end
   end

   // fixed range byte fields, eleven registers of eight
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         for (int i = 0; i < mtrl_pkg::FIXED_BYTES; i++) begin
            fix_q[i] <= 8'h00;
         end
      end else if (REG_WR && sel_fix && !bad_wr) begin
         for (int b = 0; b < 8; b++) begin
            fix_q[fix_idx*8+b] <= REG_WDATA[b*8 +: 8];
         end
      end
   end

   // variable pairs; base and mask halves written separately
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         for (int n = 0; n < mtrl_pkg::VARIABLE_COUNT; n++) begin
            var_q[n] <= mtrl_pkg::VAR_PAIR_RESET;
         end
      end else if (REG_WR && sel_var && !bad_wr) begin
         if (!REG_SEL[0]) begin
            var_q[var_idx].btype <= REG_WDATA[7:0];
            var_q[var_idx].base <= REG_WDATA[mtrl_pkg::VAR_ADDR_MSB:mtrl_pkg::VAR_ADDR_LSB];
         end else begin
            var_q[var_idx].valid <= REG_WDATA[mtrl_pkg::VAR_VALID_BIT];
            var_q[var_idx].mask <= REG_WDATA[mtrl_pkg::VAR_ADDR_MSB:mtrl_pkg::VAR_ADDR_LSB];
         end
      end
   end

   // register port answer, one cycle after the request
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         REG_DONE <= 1'b0;
         REG_FAULT <= 1'b0;
         REG_RDATA <= 64'h0000_0000_0000_0000;
      end else begin
         REG_DONE <= REG_WR || REG_RD;
         REG_FAULT <= (REG_WR && bad_wr) || (REG_RD && !REG_WR && !(sel_def || sel_fix || sel_var));
         if (REG_RD && !REG_WR) begin
            REG_RDATA <= rd_data;
         end
      end
   end

   // fixed region byte index; only the first megabyte has fixed fields
   always_comb begin
      fix_in = (LOOKUP_ADDR[35:20] == mtrl_pkg::FIRST_MEG_TOP);
      if (!LOOKUP_ADDR[19]) begin
         fix_byte = {4'h0, LOOKUP_ADDR[18:16]};
      end else if (!LOOKUP_ADDR[18]) begin
         fix_byte = mtrl_pkg::FIX16_BYTE_BASE + {3'h0, LOOKUP_ADDR[17:14]};
      end else begin
         fix_byte = mtrl_pkg::FIX4_BYTE_BASE + {1'b0, LOOKUP_ADDR[17:12]};
      end
      fix_type = fix_q[fix_byte];
   end

   // variable pair matching and overlap resolution summary
   always_comb begin
      var_any = 1'b0;
      var_uc = 1'b0;
      var_wt = 1'b0;
      var_wb = 1'b0;
      var_other = 1'b0;
      var_same = 1'b1;
      var_first = 8'h00;
      for (int n = 0; n < mtrl_pkg::VARIABLE_COUNT; n++) begin
         // addresses in mask gaps simply miss and fall through to default
         if (var_q[n].valid &&
             ((LOOKUP_ADDR[35:12] & var_q[n].mask) == (var_q[n].base & var_q[n].mask))) begin
            if (!var_any) begin
               var_first = var_q[n].btype;
            end else if (var_q[n].btype != var_first) begin
               var_same = 1'b0;
            end
            var_any = 1'b1;
            var_uc = var_uc || (var_q[n].btype == mtrl_pkg::MT_UNCACHEABLE);
            var_wt = var_wt || (var_q[n].btype == mtrl_pkg::MT_WRITE_THROUGH);
            var_wb = var_wb || (var_q[n].btype == mtrl_pkg::MT_WRITE_BACK);
            var_other = var_other || !((var_q[n].btype == mtrl_pkg::MT_UNCACHEABLE) ||
                                       (var_q[n].btype == mtrl_pkg::MT_WRITE_THROUGH) ||
                                       (var_q[n].btype == mtrl_pkg::MT_WRITE_BACK));
         end
      end
   end

   // precedence: disabled, fixed, variable, default
   always_comb begin
      if (!def_q.en) begin
         type_d = mtrl_pkg::MT_UNCACHEABLE;
      end else if (def_q.fe && fix_in) begin
         type_d = fix_type;
      end else if (var_any) begin
         // covers first megabyte too when fixed ranges are off
         if (var_uc) begin
            type_d = mtrl_pkg::MT_UNCACHEABLE;
         end else if (var_same) begin
            type_d = var_first;
         end else if (var_wt && var_wb && !var_other) begin
            type_d = mtrl_pkg::MT_WRITE_THROUGH;
         end else begin
            // undefined overlap: fall back to the safest type
            type_d = mtrl_pkg::MT_UNCACHEABLE;
         end
      end else begin
         type_d = def_q.dtype;
      end
   end

   // lookup answer registered; the access path reads it next cycle
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         LOOKUP_VALID <= 1'b0;
         LOOKUP_TYPE <= mtrl_pkg::MT_UNCACHEABLE;
      end else begin
         LOOKUP_VALID <= LOOKUP_REQ;
         if (LOOKUP_REQ) begin
            LOOKUP_TYPE <= type_d;
         end
      end
   end

   // checks next to the logic

   property p_disabled_uc;
      @(posedge SYS_CLK) disable iff (RESET)
      (LOOKUP_REQ && !def_q.en) |=> (LOOKUP_VALID && LOOKUP_TYPE == mtrl_pkg::MT_UNCACHEABLE);
   endproperty
   a_disabled_uc: assert property (p_disabled_uc) else $error("disabled unit gave cached type");

   property p_bad_default_type;
      @(posedge SYS_CLK) disable iff (RESET)
      (REG_WR && sel_def && !mtrl_pkg::type_legal(REG_WDATA[7:0]))
         |=> (REG_FAULT && REG_DONE && $stable(def_q));
   endproperty
   a_bad_default_type: assert property (p_bad_default_type) else $error("illegal default type taken");

   property p_default_reserved;
      @(posedge SYS_CLK) disable iff (RESET)
      (REG_WR && sel_def && (|REG_WDATA[63:12] || |REG_WDATA[9:8])) |=> REG_FAULT;
   endproperty
   a_default_reserved: assert property (p_default_reserved) else $error("reserved default bits accepted");

   property p_var_reserved;
      @(posedge SYS_CLK) disable iff (RESET)
      (REG_WR && sel_var && |REG_WDATA[63:36]) |=> (REG_FAULT ##1 !REG_FAULT || REG_WR);
   endproperty
   a_var_reserved: assert property (p_var_reserved) else $error("reserved pair bits accepted");

   property p_reset_clears;
      @(posedge SYS_CLK)
      RESET |=> (!def_q.en && !var_q[0].valid && !var_q[7].valid && !LOOKUP_VALID);
   endproperty
   a_reset_clears: assert property (p_reset_clears) else $error("reset left ranges enabled");

   property p_fixed_64k;
      @(posedge SYS_CLK) disable iff (RESET)
      (LOOKUP_REQ && def_q.en && def_q.fe && LOOKUP_ADDR[35:19] == 17'h0_0000)
         ##1 LOOKUP_VALID |-> LOOKUP_TYPE == $past(fix_word[0][{LOOKUP_ADDR[18:16], 3'b000} +: 8]);
   endproperty
   a_fixed_64k: assert property (p_fixed_64k) else $error("wrong 64K fixed field used");

   property p_default_fill;
      @(posedge SYS_CLK) disable iff (RESET)
      (LOOKUP_REQ && def_q.en && !(def_q.fe && fix_in) && !var_any)
         |=> LOOKUP_TYPE == $past(def_q.dtype);
   endproperty
   a_default_fill: assert property (p_default_fill) else $error("unmatched address missed default");

   property p_overlap_uc;
      @(posedge SYS_CLK) disable iff (RESET)
      (LOOKUP_REQ && def_q.en && !(def_q.fe && fix_in) && var_uc)
         |=> LOOKUP_TYPE == mtrl_pkg::MT_UNCACHEABLE;
   endproperty
   a_overlap_uc: assert property (p_overlap_uc) else $error("uncacheable overlap not honoured");

   property p_read_default;
      @(posedge SYS_CLK) disable iff (RESET)
      (REG_RD && !REG_WR && sel_def)
         |=> (REG_DONE && !REG_FAULT && REG_RDATA[11:0] == $past({def_q.en, def_q.fe, 2'b00, def_q.dtype}));
   endproperty
   a_read_default: assert property (p_read_default) else $error("default readback wrong");

   property p_lk_ans;
      @(posedge SYS_CLK) disable iff (RESET)
      LOOKUP_REQ |=> LOOKUP_VALID;
   endproperty
   a_lk_ans: assert property (p_lk_ans) else $error("lookup not answered");

   property p_lk_quiet;
      @(posedge SYS_CLK) disable iff (RESET)
      !LOOKUP_REQ |=> !LOOKUP_VALID;
   endproperty
   a_lk_quiet: assert property (p_lk_quiet) else $error("spurious lookup answer");

   property p_fix16;
      @(posedge SYS_CLK) disable iff (RESET)
      (LOOKUP_REQ && def_q.en && def_q.fe && LOOKUP_ADDR[35:18] == 18'h0_0002)
         |=> LOOKUP_TYPE ==
         $past(fix_word[{3'b000, LOOKUP_ADDR[17]} + 4'd1][{LOOKUP_ADDR[16:14], 3'b000} +: 8]);
   endproperty
   a_fix16: assert property (p_fix16) else $error("wrong 16K fixed field used");

   property p_fix4;
      @(posedge SYS_CLK) disable iff (RESET)
      (LOOKUP_REQ && def_q.en && def_q.fe && LOOKUP_ADDR[35:18] == 18'h0_0003)
         |=> LOOKUP_TYPE ==
         $past(fix_word[{1'b0, LOOKUP_ADDR[17:15]} + 4'd3][{LOOKUP_ADDR[14:12], 3'b000} +: 8]);
   endproperty
   a_fix4: assert property (p_fix4) else $error("wrong 4K fixed field used");

   property p_fix_bad;
      @(posedge SYS_CLK) disable iff (RESET)
      (REG_WR && sel_fix && !mtrl_pkg::type_legal(REG_WDATA[7:0])) |=> (REG_FAULT && REG_DONE);
   endproperty
   a_fix_bad: assert property (p_fix_bad) else $error("illegal fixed type taken");

   property p_fix_read;
      @(posedge SYS_CLK) disable iff (RESET)
      (REG_RD && !REG_WR && sel_fix)
         |=> (REG_DONE && !REG_FAULT && REG_RDATA == $past(fix_word[fix_idx]));
   endproperty
   a_fix_read: assert property (p_fix_read) else $error("fixed readback wrong");

   property p_off_var;
      @(posedge SYS_CLK) disable iff (RESET)
      (LOOKUP_REQ && def_q.en && !def_q.fe && fix_in && var_any && !var_uc && var_same)
         |=> LOOKUP_TYPE == $past(var_first);
   endproperty
   a_off_var: assert property (p_off_var) else $error("pair ignored, fixed off");

endmodule

// ===== hw/mtrl_pkg.sv
/*
 * mtrl_pkg: constants, field layouts and carrier types of the memory type
 * range lookup unit.
 * Assumes: imported by nobody; every user writes mtrl_pkg::name.
 */
package mtrl_pkg;

   // memory type encodings
   localparam logic [7:0] MT_UNCACHEABLE = 8'h00;
   localparam logic [7:0] MT_WRITE_COMBINING = 8'h01;
   localparam logic [7:0] MT_WRITE_THROUGH = 8'h04;
   localparam logic [7:0] MT_WRITE_PROTECTED = 8'h05;
   localparam logic [7:0] MT_WRITE_BACK = 8'h06;

   // register selects on the model register port
   localparam logic [7:0] SEL_DEFAULT_TYPE_CONTROL = 8'h00;
   localparam logic [7:0] SEL_FIXED_FIRST = 8'h01;
   localparam logic [7:0] SEL_FIXED_LAST = 8'h0B;
   localparam logic [3:0] SEL_VARIABLE_GROUP = 4'h1;
   localparam int FIXED_COUNT = 11;
   localparam int VARIABLE_COUNT = 8;
   localparam int FIXED_BYTES = 88;

   // field positions
   localparam int DEF_FE_BIT = 10;
   localparam int DEF_EN_BIT = 11;
   localparam int VAR_VALID_BIT = 11;
   localparam int VAR_ADDR_LSB = 12;
   localparam int VAR_ADDR_MSB = 35;

   // reserved bit masks; a write with any of these set faults
   localparam logic [63:0] DEF_RSVD_MASK = 64'hFFFF_FFFF_FFFF_F300;
   localparam logic [63:0] BASE_RSVD_MASK = 64'hFFFF_FFF0_0000_0F00;
   localparam logic [63:0] MASK_RSVD_MASK = 64'hFFFF_FFF0_0000_07FF;

   // fixed region decode
   localparam logic [15:0] FIRST_MEG_TOP = 16'h0000;
   localparam logic [6:0] FIX16_BYTE_BASE = 7'h08;
   localparam logic [6:0] FIX4_BYTE_BASE = 7'h18;

   // default-type control register contents
   typedef struct packed {
      logic en;
      logic fe;
      logic [7:0] dtype;
   } mtrl_def_ctl_t;

   // one variable range pair
   typedef struct packed {
      logic [23:0] base;
      logic [7:0] btype;
      logic [23:0] mask;
      logic valid;
   } mtrl_var_pair_t;

   localparam mtrl_def_ctl_t DEF_CTL_RESET = '{en: 1'b0, fe: 1'b0, dtype: 8'h00};
   localparam mtrl_var_pair_t VAR_PAIR_RESET = '{base: 24'h00_0000, btype: 8'h00,
                                                 mask: 24'h00_0000, valid: 1'b0};

   // legal memory type encoding check
   function automatic logic type_legal(input logic [7:0] t);
      return (t == MT_UNCACHEABLE) || (t == MT_WRITE_COMBINING) ||
             (t == MT_WRITE_THROUGH) || (t == MT_WRITE_PROTECTED) ||
             (t == MT_WRITE_BACK);
   endfunction

endpackage

// ===== tb/mtrl_core_model.sv
/*
 * mtrl_core_model: stand-in for the core register-write logic and the
 * memory access path that face the lookup unit.
 * Assumes: the bench calls one task at a time; all inputs move on falling edges.
 */
`timescale 1ns/100ps
module mtrl_core_model (
   // clock
   input wire logic SYS_CLK,
   // model register requests
   output logic REG_WR,
   output logic REG_RD,
   output logic [7:0] REG_SEL,
   output logic [63:0] REG_WDATA,
   // lookup requests
   output logic LOOKUP_REQ,
   output logic [35:0] LOOKUP_ADDR
);
   // idle at time zero
   initial begin
      REG_WR = 1'b0;
      REG_RD = 1'b0;
      REG_SEL = 8'h00;
      REG_WDATA = 64'h0;
      LOOKUP_REQ = 1'b0;
      LOOKUP_ADDR = 36'h0;
   end

   // one request across exactly one rising edge; released strobes go low and select
   // and data are inverted so a stale value can never pass for a live one
   task automatic reg_cmd(input logic wr, input logic [7:0] sel, input logic [63:0] d);
      @(negedge SYS_CLK);
      REG_WR = wr;
      REG_RD = !wr;
      REG_SEL = sel;
      REG_WDATA = d;
      @(negedge SYS_CLK);
      REG_WR = 1'b0;
      REG_RD = 1'b0;
      REG_SEL = ~sel;
      REG_WDATA = ~d;
   endtask

   // one lookup across one rising edge
   task automatic lookup(input logic [35:0] a);
      @(negedge SYS_CLK);
      LOOKUP_REQ = 1'b1;
      LOOKUP_ADDR = a;
      @(negedge SYS_CLK);
      LOOKUP_REQ = 1'b0;
      LOOKUP_ADDR = ~a;
   endtask
endmodule

// ===== tb/tb_memory_type_range_lookup.sv
/*
 * tb_memory_type_range_lookup: self-checking bench of the lookup unit.
 * Assumes: mtrl_core_model drives the requests; a shadow of the registers
 * predicts every answer, and a monitor compares answers in order.
 */
`timescale 1ns/100ps
module tb_memory_type_range_lookup;
   logic sys_clk, reset, reg_wr, reg_rd, reg_done, reg_fault, lookup_req, lookup_valid;
   logic [7:0] reg_sel, lookup_type;
   logic [63:0] reg_wdata, reg_rdata;
   logic [35:0] lookup_addr;
   int miscompares = 0;
   int check_count = 0;
   logic [65:0] reg_q[$];
   logic [7:0] lk_q[$];
   logic [63:0] def_s, fix_s[11], base_s[8], mask_s[8];
   logic [7:0] legal[5] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h06};
   int rsv[5] = '{8, 9, 12, 35, 63};
   logic [35:0] edge_a[8] = '{36'h7_FFFF, 36'h8_0000, 36'h9_C000, 36'hB_FFFF,
                              36'hC_0000, 36'hF_FFFF, 36'h10_0000, 36'hF_FFFF_FFFF};
   logic [63:0] bad_b[4] = '{64'h0106, 64'h0806, 64'h10_0000_0006, 64'h0002};
   logic [63:0] bad_m[4] = '{64'h0801, 64'h0C00, 64'h10_0000_0800, 64'h8000_0000_0000_0000};

   // 250 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   mtrl_core_model core (.SYS_CLK(sys_clk), .REG_WR(reg_wr), .REG_RD(reg_rd),
      .REG_SEL(reg_sel), .REG_WDATA(reg_wdata), .LOOKUP_REQ(lookup_req),
      .LOOKUP_ADDR(lookup_addr));
   mtrl_lookup_unit uut (.SYS_CLK(sys_clk), .RESET(reset), .REG_WR(reg_wr), .REG_RD(reg_rd),
      .REG_SEL(reg_sel), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .REG_DONE(reg_done),
      .REG_FAULT(reg_fault), .LOOKUP_REQ(lookup_req), .LOOKUP_ADDR(lookup_addr),
      .LOOKUP_VALID(lookup_valid), .LOOKUP_TYPE(lookup_type));

   // predicted type from the shadow registers
   function automatic logic [7:0] ref_type(input logic [35:0] a);
      logic [7:0] t, bt;
      logic hit;
      logic [3:0] fi;
      logic [2:0] bi;
      logic [35:0] m;
      t = def_s[7:0];
      hit = 1'b0;
      if (!def_s[11]) return 8'h00;
      if (def_s[10] && a < 36'h10_0000) begin
         fi = (a < 36'h8_0000) ? 4'h0 : (a < 36'hC_0000) ? 4'h1 + 4'(a[17]) : 4'h3 + 4'(a[17:15]);
         bi = (a < 36'h8_0000) ? a[18:16] : (a < 36'hC_0000) ? a[16:14] : a[14:12];
         return fix_s[fi][bi*8 +: 8];
      end
      for (int i = 0; i < 8; i++) begin
         m = {mask_s[i][35:12], 12'h000};
         if (mask_s[i][11] && (a & m) == ({base_s[i][35:12], 12'h000} & m)) begin
            bt = base_s[i][7:0];
            if (!hit) t = bt;
            else if (t != bt) t = ({t, bt} == 16'h0406 || {t, bt} == 16'h0604) ? 8'h04 : 8'h00;
            hit = 1'b1;
         end
      end
      return t;
   endfunction

   // shadow after any reset: everything cleared
   task automatic clr();
      def_s = 64'h0;
      foreach (fix_s[i]) fix_s[i] = 64'h0;
      foreach (base_s[i]) base_s[i] = 64'h0;
      foreach (mask_s[i]) mask_s[i] = 64'h0;
   endtask

   // write, noting whether it must fault; a faulting write leaves the shadow alone
   task automatic w(input logic [7:0] sel, input logic [63:0] d, input logic f);
      reg_q.push_back({1'b0, f, 64'h0});
      core.reg_cmd(1'b1, sel, d);
      if (!f) begin
         if (sel == 8'h00) def_s = d;
         else if (sel <= 8'h0B) fix_s[sel - 8'h01] = d;
         else if (sel[0]) mask_s[(sel - 8'h11) >> 1] = d;
         else base_s[(sel - 8'h10) >> 1] = d;
      end
   endtask

   task automatic r(input logic [7:0] sel, input logic [63:0] e, input logic f);
      reg_q.push_back({1'b1, f, e});
      core.reg_cmd(1'b0, sel, 64'h0);
   endtask

   task automatic lk(input logic [35:0] a);
      lk_q.push_back(ref_type(a));
      core.lookup(a);
   endtask

   task automatic lk_rand(input logic [35:0] lo, input int unsigned span, input int n);
      for (int i = 0; i < n; i++) lk(lo + 36'($urandom % span));
   endtask

   // monitor: every answer takes the oldest note; a missing note never matches
   always @(negedge sys_clk) begin
      logic [65:0] e;
      logic [7:0] et;
      if (!reset && reg_done === 1'b1) begin
         e = (reg_q.size() > 0) ? reg_q.pop_front() : {66{1'b1}};
         check_count++;
         if (reg_fault !== e[64] || (e[65] && reg_rdata !== e[63:0])) begin
            miscompares++;
            $display("BAD %0t register answer, expected %h", $time, e);
         end
      end
      if (!reset && lookup_valid === 1'b1) begin
         et = (lk_q.size() > 0) ? lk_q.pop_front() : 8'hFF;
         check_count++;
         if (lookup_type !== et) begin
            miscompares++;
            $display("BAD %0t lookup type %h, expected %h", $time, lookup_type, et);
         end
      end
   end

   task automatic results();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      logic [63:0] d;
      reset = 1'b1;
      void'($urandom(97019));
      clr();
      repeat (2) @(negedge sys_clk);
      reset = 1'b0;
      // cleared after reset, uncacheable everywhere
      r(8'h00, 64'h0, 1'b0);
      r(8'h11, 64'h0, 1'b0);
      lk_rand(36'h0, 32'hFFFF_FFFF, 8);
      // default field encodings and reserved bits
      for (int t = 0; t < 8; t++) w(8'h00, 64'(t), !(t inside {0, 1, 4, 5, 6}));
      r(8'h00, def_s, 1'b0);
      foreach (rsv[i]) w(8'h00, 64'h1 << rsv[i], 1'b1);
      w(8'h0C, 64'h0, 1'b1);
      r(8'h20, 64'h0, 1'b1);
      // fixed registers with random legal bytes
      for (int i = 0; i < 11; i++) begin
         for (int b = 0; b < 8; b++) d[b*8 +: 8] = legal[$urandom % 5];
         w(8'h01 + 8'(i), d, 1'b0);
      end
      w(8'h05, 64'h0003, 1'b1);
      r(8'h05, fix_s[4], 1'b0);
      w(8'h00, 64'h0406, 1'b0);
      lk_rand(36'h0, 32'h0010_0000, 8);
      w(8'h00, 64'h0C05, 1'b0);
      foreach (edge_a[i]) lk(edge_a[i]);
      lk_rand(36'h0, 32'h0010_0000, 40);
      // variable pairs: overlaps, an invalid pair, a split mask
      w(8'h10, 64'h0006, 1'b0);
      w(8'h11, 64'h000F_FC00_0800, 1'b0);
      w(8'h12, 64'h00F0_0000, 1'b0);
      w(8'h13, 64'h000F_FFF0_0800, 1'b0);
      w(8'h14, 64'h0200_0004, 1'b0);
      w(8'h15, 64'h000F_FE00_0800, 1'b0);
      w(8'h18, 64'h0100_0005, 1'b0);
      w(8'h19, 64'h000F_FF00_0000, 1'b0);
      w(8'h1A, 64'h8000_0001, 1'b0);
      w(8'h1B, 64'h000F_8010_0800, 1'b0);
      foreach (bad_b[i]) w(8'h1E, bad_b[i], 1'b1);
      foreach (bad_m[i]) w(8'h1F, bad_m[i], 1'b1);
      r(8'h1F, 64'h0, 1'b0);
      r(8'h1B, mask_s[5], 1'b0);
      foreach (edge_a[i]) lk(edge_a[i]);
      lk_rand(36'h0, 32'h0800_0000, 40);
      lk_rand(36'h8000_0000, 32'h0040_0000, 16);
      lk_rand(36'h0, 32'h0010_0000, 16);
      // fixed ranges off, then everything off
      w(8'h00, 64'h0805, 1'b0);
      lk_rand(36'h0, 32'h0010_0000, 16);
      w(8'h00, 64'h0405, 1'b0);
      lk_rand(36'h0, 32'h0800_0000, 8);
      // second reset in mid-run
      w(8'h00, 64'h0C06, 1'b0);
      @(negedge sys_clk);
      reset = 1'b1;
      repeat (2) @(negedge sys_clk);
      reset = 1'b0;
      clr();
      r(8'h11, 64'h0, 1'b0);
      lk_rand(36'h0, 32'h0800_0000, 8);
      repeat (4) @(negedge sys_clk);
      if (reg_q.size() != 0 || lk_q.size() != 0) begin
         miscompares++;
         $display("BAD %0t answers missing", $time);
      end
      results();
   end

   // hang guard
   initial begin
      #400000;
      miscompares++;
      $display("BAD %0t run hung", $time);
      results();
   end
endmodule
